// ### lfmc_pkg.sv
// Constants, register map and state codes of the LED fault and mode control block.
// Assumes a single 10 MHz clock and the plain register port of lfmc_ctrl.
package lfmc_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
  localparam int unsigned TMR_W        = 27;

  // Shared 16-level time table, in milliseconds
  localparam logic [15:0][13:0] TIME_MS = {
    14'd8050, 14'd7060, 14'd5990, 14'd5010, 14'd4020, 14'd3040, 14'd2500, 14'd2060,
    14'd1520, 14'd1070, 14'd800,  14'd540,  14'd360,  14'd180,  14'd90,   14'd0
  };

  // Fault sensing
  localparam logic [7:0] PWM_EVAL_MIN = 8'h19;  // Sensing only above this PWM value
  localparam logic [1:0] FAULT_RUN    = 2'h3;   // Consecutive faulty readings to flag

  // Register byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_PAUSE  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_OPEN   = 8'h10;
  localparam logic [7:0] REG_SHORT  = 8'h14;

  // CTRL fields
  localparam int unsigned CTRL_CHIP_EN = 0;
  localparam int unsigned CTRL_AUTO    = 1;
  localparam int unsigned CTRL_MC51    = 2;
  localparam int unsigned CTRL_LOD_ACT = 3;
  localparam int unsigned CTRL_LSD_ACT = 4;
  localparam int unsigned CTRL_LSD_THR = 8;   // 4-bit field
  localparam logic [3:0]  LSD_THR_RST  = 4'h0;

  // CMD fields, write one to act
  localparam int unsigned CMD_START     = 0;
  localparam int unsigned CMD_STOP      = 1;
  localparam int unsigned CMD_LOD_CLEAR = 2;
  localparam int unsigned CMD_LSD_CLEAR = 3;

  // PAUSE fields
  localparam int unsigned PAUSE_LEAD  = 0;   // 4-bit field
  localparam int unsigned PAUSE_TRAIL = 4;   // 4-bit field

  // STATUS fields
  localparam int unsigned STAT_STATE   = 0;  // 4-bit one-hot
  localparam int unsigned STAT_OT      = 4;
  localparam int unsigned STAT_STARTED = 5;
  localparam int unsigned STAT_PHASE   = 8;  // 4-bit one-hot

  typedef enum logic [3:0] {
    ST_INIT  = 4'b0001,
    ST_STBY  = 4'b0010,
    ST_NORM  = 4'b0100,
    ST_AOFF  = 4'b1000
  } lfmc_state_t;

  typedef enum logic [3:0] {
    PH_IDLE  = 4'b0001,
    PH_LEAD  = 4'b0010,
    PH_RUN   = 4'b0100,
    PH_TRAIL = 4'b1000
  } lfmc_phase_t;

endpackage

// ### lfmc_ctrl.sv
// Operating state machine, open/short fault sensing, thermal gating and pause units
// of a matrix LED driver, with a small register port for the host.
// Assumes comparator and temperature inputs come from pins (synchronised here) and that
// PWM values, dot currents, PWM period ticks and engine handshakes come from same-clock logic.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

module lfmc_ctrl
  import lfmc_pkg::*;
#(
  parameter int unsigned N_LED      = 12,
  parameter int unsigned CYC_PER_MS = lfmc_pkg::CYC_PER_MS
)(
  input  wire logic                   clk,           // 10 MHz clock
  input  wire logic                   rst_n,         // Synchronous reset, active low
  input  wire logic [7:0]             reg_addr,      // Register byte address
  input  wire logic [31:0]            reg_wdata,     // Register write data
  input  wire logic                   reg_wr,        // Write strobe
  input  wire logic                   reg_rd,        // Read strobe
  output logic      [31:0]            reg_rdata,     // Read data, cycle after strobe
  input  wire logic [N_LED*8-1:0]     led_pwm,       // Effective PWM per LED
  input  wire logic [N_LED*8-1:0]     dot_current,   // Dot current per LED
  input  wire logic [N_LED-1:0]       pwm_tick,      // One pulse per PWM period per LED
  input  wire logic [N_LED-1:0]       open_cmp,      // Cathode below open threshold (pin)
  input  wire logic [N_LED-1:0]       short_cmp,     // Cathode above short threshold (pin)
  input  wire logic                   over_temp,     // Over-temperature indication (pin)
  input  wire logic [7:0]             first_pwm1,    // First PWM of first enabled engine unit
  input  wire logic [7:0]             last_pwm5,     // Fifth PWM of last enabled engine unit
  input  wire logic                   engine_done,   // Engine units finished their run
  output logic                        engine_go,     // Pulse: start the engine units
  output logic                        pause_active,  // A pause unit is playing
  output logic      [7:0]             pause_pwm,     // Brightness during a pause unit
  output logic      [N_LED-1:0]       led_on,        // Per-dot drive enable
  output logic                        open_thr_high, // Select doubled open threshold
  output logic      [3:0]             short_thr_sel, // Short comparator level select
  output lfmc_pkg::lfmc_state_t       state          // Operating state
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    lfmc_state_t             st;
    lfmc_phase_t             ph;
    logic [N_LED-1:0]        open_s1;
    logic [N_LED-1:0]        open_s2;
    logic [N_LED-1:0]        short_s1;
    logic [N_LED-1:0]        short_s2;
    logic                    ot_s1;
    logic                    ot_s2;
    logic                    chip_en;
    logic                    auto_mode;
    logic                    mc51;
    logic                    lod_act;
    logic                    lsd_act;
    logic [3:0]              lsd_thr;
    logic [3:0]              lead_code;
    logic [3:0]              trail_code;
    logic                    started;
    logic [TMR_W-1:0]        tmr;
    logic [N_LED-1:0][1:0]   ocnt;
    logic [N_LED-1:0][1:0]   scnt;
    logic [N_LED-1:0]        lod;
    logic [N_LED-1:0]        lsd;
    logic [N_LED-1:0]        led_on;
    logic                    eng_go;
    logic [7:0]              ppwm;
    logic [31:0]             rdata;
  } lfmc_regs_t;

  lfmc_regs_t q;
  lfmc_regs_t d;

  logic [N_LED-1:0] eval_ok;
  logic [N_LED-1:0] lit;

  ////////////////////////////////////////////////////////////////////////////
  // Per-LED qualifiers
  genvar gi;
  generate
    for (gi = 0; gi < N_LED; gi++)
    begin : g_led
      assign eval_ok[gi] = led_pwm[gi*8 +: 8] > PWM_EVAL_MIN;
      assign lit[gi]     = (led_pwm[gi*8 +: 8] != 8'h00) && (dot_current[gi*8 +: 8] != 8'h00);
    end
  endgenerate

  // Pause length in cycles; the table is in milliseconds
  function automatic logic [TMR_W-1:0] pause_cycles(input logic [3:0] code);
    logic [63:0] c;
    c = 64'(TIME_MS[code]) * 64'(CYC_PER_MS);
    return c[TMR_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic       wr_ctrl;
  logic       wr_cmd;
  logic       cmd_start;
  logic       cmd_stop;
  logic       clr_open;
  logic       clr_short;
  logic       any_eff;
  logic       short_hit;

  assign wr_ctrl   = reg_wr && (reg_addr == REG_CTRL);
  assign wr_cmd    = reg_wr && (reg_addr == REG_CMD);
  assign cmd_start = wr_cmd && reg_wdata[CMD_START];
  assign cmd_stop  = wr_cmd && reg_wdata[CMD_STOP];
  assign clr_open  = wr_cmd && reg_wdata[CMD_LOD_CLEAR];
  assign clr_short = wr_cmd && reg_wdata[CMD_LSD_CLEAR];
  // Autonomous LEDs count only once the pattern has been started
  assign any_eff   = (|lit) && (!q.auto_mode || q.started);

  always_comb
  begin
    d         = q;
    short_hit = 1'b0;
    d.eng_go  = 1'b0;

    // Pin synchronisers
    d.open_s1  = open_cmp;
    d.open_s2  = q.open_s1;
    d.short_s1 = short_cmp;
    d.short_s2 = q.short_s1;
    d.ot_s1    = over_temp;
    d.ot_s2    = q.ot_s1;

    // Register writes
    if (wr_ctrl)
    begin
      d.chip_en   = reg_wdata[CTRL_CHIP_EN];
      d.auto_mode = reg_wdata[CTRL_AUTO];
      d.mc51      = reg_wdata[CTRL_MC51];
      d.lod_act   = reg_wdata[CTRL_LOD_ACT];
      d.lsd_act   = reg_wdata[CTRL_LSD_ACT];
      d.lsd_thr   = reg_wdata[CTRL_LSD_THR +: 4];
    end
    if (reg_wr && (reg_addr == REG_PAUSE))
    begin
      d.lead_code  = reg_wdata[PAUSE_LEAD +: 4];
      d.trail_code = reg_wdata[PAUSE_TRAIL +: 4];
    end
    if (cmd_start)
      d.started = 1'b1;
    if (cmd_stop)
      d.started = 1'b0;

    // Clears first, so a fault reading in the same cycle still sets its flag
    if (clr_open)
      d.lod = '0;
    if (clr_short)
      d.lsd = '0;

    // Fault sensing, one reading per PWM period
    for (int i = 0; i < N_LED; i++)
    begin
      if (q.st != ST_NORM)
      begin
        d.ocnt[i] = 2'h0;
        d.scnt[i] = 2'h0;
      end
      else if (pwm_tick[i] && eval_ok[i])
      begin
        if (q.open_s2[i])
        begin
          if (q.ocnt[i] != FAULT_RUN)
            d.ocnt[i] = q.ocnt[i] + 2'h1;
          if (q.ocnt[i] >= FAULT_RUN - 2'h1)
            d.lod[i] = 1'b1;
        end
        else
        begin
          d.ocnt[i] = 2'h0;
          d.lod[i]  = 1'b0;
        end
        if (q.short_s2[i])
        begin
          if (q.scnt[i] != FAULT_RUN)
            d.scnt[i] = q.scnt[i] + 2'h1;
          if (q.scnt[i] >= FAULT_RUN - 2'h1)
          begin
            d.lsd[i]  = 1'b1;
            short_hit = 1'b1;
          end
        end
        else
        begin
          d.scnt[i] = 2'h0;
          d.lsd[i]  = 1'b0;
        end
      end
    end

    // Operating state machine
    case (q.st)
      ST_INIT:
        if (q.chip_en)
          d.st = ST_STBY;
      ST_STBY:
        if (any_eff)
          d.st = ST_NORM;
      ST_NORM:
        if (short_hit && q.lsd_act)
          d.st = ST_AOFF;
        else if (!any_eff || cmd_stop)
          d.st = ST_STBY;
      ST_AOFF:
        if (clr_short)
          d.st = ST_STBY;
      default:
        d.st = ST_INIT;
    endcase

    // Pause units around the engine run
    case (q.ph)
      PH_IDLE:
        if (cmd_start && q.auto_mode)
        begin
          if (q.lead_code == 4'h0)
          begin
            d.ph     = PH_RUN;
            d.eng_go = 1'b1;
          end
          else
          begin
            d.ph  = PH_LEAD;
            d.tmr = pause_cycles(q.lead_code) - TMR_W'(1);
          end
        end
      PH_LEAD:
        if (q.tmr == '0)
        begin
          d.ph     = PH_RUN;
          d.eng_go = 1'b1;
        end
        else
          d.tmr = q.tmr - TMR_W'(1);
      PH_RUN:
        if (engine_done)
        begin
          if (q.trail_code == 4'h0)
            d.ph = PH_IDLE;
          else
          begin
            d.ph  = PH_TRAIL;
            d.tmr = pause_cycles(q.trail_code) - TMR_W'(1);
          end
        end
      PH_TRAIL:
        if (q.tmr == '0)
          d.ph = PH_IDLE;
        else
          d.tmr = q.tmr - TMR_W'(1);
      default:
        d.ph = PH_IDLE;
    endcase
    // A stop ends the pattern wherever it stands
    if (cmd_stop)
    begin
      d.ph     = PH_IDLE;
      d.eng_go = 1'b0;
    end

    // Pause brightness follows the neighbouring engine unit
    if (d.ph == PH_LEAD)
      d.ppwm = first_pwm1;
    else if (d.ph == PH_TRAIL)
      d.ppwm = last_pwm5;
    else
      d.ppwm = 8'h00;

    // Dot drive: only in normal, never while hot, open dots dropped on request
    for (int i = 0; i < N_LED; i++)
      d.led_on[i] = (d.st == ST_NORM) && !q.ot_s2
                    && !(q.lod_act && d.lod[i]);

    // Read data, valid only in the cycle after the strobe
    d.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:
        begin
          d.rdata[CTRL_CHIP_EN]      = q.chip_en;
          d.rdata[CTRL_AUTO]         = q.auto_mode;
          d.rdata[CTRL_MC51]         = q.mc51;
          d.rdata[CTRL_LOD_ACT]      = q.lod_act;
          d.rdata[CTRL_LSD_ACT]      = q.lsd_act;
          d.rdata[CTRL_LSD_THR +: 4] = q.lsd_thr;
        end
        REG_PAUSE:
        begin
          d.rdata[PAUSE_LEAD +: 4]  = q.lead_code;
          d.rdata[PAUSE_TRAIL +: 4] = q.trail_code;
        end
        REG_STATUS:
        begin
          d.rdata[STAT_STATE +: 4] = q.st;
          d.rdata[STAT_OT]         = q.ot_s2;
          d.rdata[STAT_STARTED]    = q.started;
          d.rdata[STAT_PHASE +: 4] = q.ph;
        end
        REG_OPEN:
          d.rdata[N_LED-1:0] = q.lod;
        REG_SHORT:
          d.rdata[N_LED-1:0] = q.lsd;
        default:
          d.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q            <= '0;
      q.st         <= ST_INIT;
      q.ph         <= PH_IDLE;
      q.lsd_thr    <= LSD_THR_RST;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata     = q.rdata;
  assign engine_go     = q.eng_go;
  assign pause_active  = (q.ph == PH_LEAD) || (q.ph == PH_TRAIL);
  assign pause_pwm     = q.ppwm;
  assign led_on        = q.led_on;
  assign open_thr_high = q.mc51;
  assign short_thr_sel = q.lsd_thr;
  assign state         = q.st;

endmodule

// ### lfmc_ctrl_monitor.sv
// Port checker for lfmc_ctrl: state moves, drive gating, thresholds, pause and read timing.
// Assumes a bind to lfmc_ctrl and one clock domain.
`timescale 1ns/1ps
module lfmc_ctrl_monitor
  import lfmc_pkg::*;
#(
  parameter int unsigned N_LED = 12
)(
  input wire logic                  clk,           // Clock
  input wire logic                  rst_n,         // Reset
  input wire logic [7:0]            reg_addr,      // Address
  input wire logic [31:0]           reg_wdata,     // Write data
  input wire logic                  reg_wr,        // Write strobe
  input wire logic                  reg_rd,        // Read strobe
  input wire logic [31:0]           reg_rdata,     // Read data
  input wire logic                  over_temp,     // Hot pin
  input wire logic [7:0]            first_pwm1,    // Lead brightness
  input wire logic                  engine_go,     // Engine start
  input wire logic                  pause_active,  // Pause playing
  input wire logic [7:0]            pause_pwm,     // Pause brightness
  input wire logic [N_LED-1:0]      led_on,        // Dot enables
  input wire logic                  open_thr_high, // Open threshold
  input wire logic [3:0]            short_thr_sel, // Short threshold
  input wire lfmc_pkg::lfmc_state_t state          // State
);
  import lfmc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic lsd_clr_wr;
  assign lsd_clr_wr = reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_LSD_CLEAR];
  //////////////////////////////////////////////////
  a_reset_init: assert property ($rose(rst_n) |-> state == ST_INIT)
    else $error("state not initial after reset");
  a_init_hold: assert property (state == ST_INIT && !reg_wr && !$past(reg_wr)
      |=> state == ST_INIT)
    else $error("initial state left without a write");
  a_off_dark: assert property (state != ST_NORM |-> led_on == '0)
    else $error("dot driven outside normal state");
  a_temp_dark: assert property (over_temp [*4] |=> led_on == '0)
    else $error("dot driven while hot");
  a_thr_follow: assert property (reg_wr && reg_addr == REG_CTRL |-> ##2
      open_thr_high == $past(reg_wdata[CTRL_MC51], 2)
      && short_thr_sel == $past(reg_wdata[CTRL_LSD_THR +: 4], 2))
    else $error("threshold selects do not follow control");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  a_norm_entry: assert property ($rose(state == ST_NORM) |-> $past(state) == ST_STBY)
    else $error("normal entered not from standby");
  a_aoff_exit: assert property ($past(state) == ST_AOFF && state != ST_AOFF |->
      state == ST_STBY && ($past(lsd_clr_wr) || $past(lsd_clr_wr, 2)))
    else $error("all-off state left wrongly");
  a_go_pulse: assert property (engine_go |=> !engine_go)
    else $error("engine start longer than one cycle");
  a_lead_pwm: assert property ($rose(engine_go) && $past(pause_active) |->
      $past(pause_pwm) == $past(first_pwm1, 2))
    else $error("lead pause brightness wrong");
  c_aoff: cover property (state == ST_AOFF);
  c_go: cover property (engine_go);
  c_hot: cover property (over_temp && state == ST_NORM);
  c_pause: cover property (pause_active);
endmodule

// ### lfmc_far_model.sv
// Model of the PWM time base and engine units beside lfmc_ctrl.
// Assumes the same clock; every LED takes its reading on one shared tick.
`timescale 1ns/1ps
module lfmc_far_model #(
  parameter int unsigned N_LED    = 12,
  parameter int unsigned PERIOD   = 8,
  parameter int unsigned DONE_DLY = 5
)(
  input  wire logic             clk,        // Clock
  input  wire logic             rst_n,      // Reset
  input  wire logic             engine_go,  // Start pulse
  output logic      [N_LED-1:0] pwm_tick,   // Period pulses
  output logic                  engine_done // Run finished
);
  int unsigned tcnt;
  int unsigned dcnt;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tcnt        <= 0;
      dcnt        <= 0;
      pwm_tick    <= '0;
      engine_done <= 1'h0;
    end
    else
    begin
      // Short period keeps fault runs brief; a real PWM period is far longer
      tcnt        <= (tcnt == PERIOD - 1) ? 0 : tcnt + 1;
      pwm_tick    <= {N_LED{tcnt == PERIOD - 1}};
      engine_done <= (dcnt == 1);
      if (engine_go)
        dcnt <= DONE_DLY;
      else if (dcnt != 0)
        dcnt <= dcnt - 1;
    end
  end
endmodule

// ### tb_lfmc_ctrl.sv
// Self-checking bench for lfmc_ctrl: register, state, fault, thermal and pause tests.
// Assumes lfmc_far_model supplies PWM ticks every 8 cycles and engine completion.
`timescale 1ns/1ps
module tb_lfmc_ctrl;
  import lfmc_pkg::*;
  localparam int unsigned N = 12;
  logic              clk, rst_n, reg_wr, reg_rd, over_temp, engine_done, engine_go;
  logic              pause_active, open_thr_high;
  logic [7:0]        reg_addr, first_pwm1, last_pwm5, pause_pwm;
  logic [31:0]       reg_wdata, reg_rdata;
  logic [N*8-1:0]    led_pwm, dot_current;
  logic [N-1:0]      pwm_tick, open_cmp, short_cmp, led_on;
  logic [3:0]        short_thr_sel;
  lfmc_state_t       state;
  int                fails, checks, n;
  lfmc_ctrl #(.N_LED(N), .CYC_PER_MS(1)) i_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .led_pwm(led_pwm),
    .dot_current(dot_current), .pwm_tick(pwm_tick), .open_cmp(open_cmp),
    .short_cmp(short_cmp), .over_temp(over_temp), .first_pwm1(first_pwm1),
    .last_pwm5(last_pwm5), .engine_done(engine_done), .engine_go(engine_go),
    .pause_active(pause_active), .pause_pwm(pause_pwm), .led_on(led_on),
    .open_thr_high(open_thr_high), .short_thr_sel(short_thr_sel), .state(state));
  lfmc_far_model #(.N_LED(N)) i_far (
    .clk(clk), .rst_n(rst_n), .engine_go(engine_go), .pwm_tick(pwm_tick),
    .engine_done(engine_done));
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  //////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr    <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk);
    reg_rd   <= 1'h0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata);
  endtask
  function automatic logic sig(input int w);
    case (w)
      0:       return engine_go;
      1:       return pwm_tick[0];
      default: return !pause_active;
    endcase
  endfunction
  // Counts edges until the chosen signal was high before the edge
  task automatic wait_for(input int w, input int lim, output int k);
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
      if (k > lim)
      begin
        fails++;
        results();
      end
    end while (sig(w) !== 1'h1);
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////
  initial
  begin
    {fails, checks} = 0;
    {rst_n, reg_wr, reg_rd, over_temp, reg_addr, reg_wdata} <= '0;
    {led_pwm, dot_current, open_cmp, short_cmp} <= '0;
    first_pwm1 <= 8'h5a;
    last_pwm5  <= 8'ha5;
    cyc(5);
    rst_n <= 1'h1;
    rd(REG_STATUS, 32'h101);
    rd(8'h40, 32'h0);
    wr(REG_CTRL, 32'h50d);
    cyc(2);
    chk("state", ST_STBY, state);
    chk("open_thr_high", 1'h1, open_thr_high);
    chk("short_thr_sel", 4'h5, short_thr_sel);
    rd(REG_CTRL, 32'h50d);
    $display("test setup done");
    led_pwm[15:0]     <= 16'h191a;
    dot_current[15:0] <= 16'h8080;
    cyc(3);
    chk("state", ST_NORM, state);
    wait_for(1, 20, n);
    open_cmp <= 12'h003;
    cyc(20);
    rd(REG_OPEN, 32'h0);
    cyc(8);
    rd(REG_OPEN, 32'h1);
    chk("led_on0", 1'h0, led_on[0]);
    chk("led_on1", 1'h1, led_on[1]);
    open_cmp <= 12'h000;
    wr(REG_CMD, 32'h4);
    rd(REG_OPEN, 32'h0);
    cyc(2);
    chk("led_on0", 1'h1, led_on[0]);
    $display("test open done");
    wait_for(1, 20, n);
    short_cmp <= 12'h001;
    cyc(30);
    rd(REG_SHORT, 32'h1);
    chk("state", ST_NORM, state);
    short_cmp <= 12'h000;
    cyc(12);
    rd(REG_SHORT, 32'h0);
    wr(REG_CTRL, 32'h51d);
    wait_for(1, 20, n);
    short_cmp <= 12'h001;
    cyc(30);
    chk("state", ST_AOFF, state);
    chk("led_on", 12'h000, led_on);
    wr(REG_CMD, 32'h2);
    cyc(2);
    chk("state", ST_AOFF, state);
    short_cmp <= 12'h000;
    wr(REG_CMD, 32'h8);
    rd(REG_SHORT, 32'h0);
    cyc(3);
    chk("state", ST_NORM, state);
    $display("test short done");
    over_temp <= 1'h1;
    cyc(4);
    chk("led_on", 12'h000, led_on);
    rd(REG_STATUS, 32'h114);
    over_temp <= 1'h0;
    cyc(4);
    chk("led_on0", 1'h1, led_on[0]);
    $display("test thermal done");
    // Dot current off keeps LED0 above the sensing PWM floor, so only the state gate stops flags
    dot_current <= '0;
    cyc(3);
    chk("state", ST_STBY, state);
    {open_cmp, short_cmp} <= '1;
    cyc(40);
    rd(REG_OPEN, 32'h0);
    rd(REG_SHORT, 32'h0);
    {open_cmp, short_cmp} <= '0;
    $display("test standby done");
    wr(REG_PAUSE, 32'h21);
    rd(REG_PAUSE, 32'h21);
    wr(REG_CTRL, 32'h51f);
    dot_current[7:0] <= 8'h80;
    cyc(3);
    chk("state", ST_STBY, state);
    wr(REG_CMD, 32'h1);
    cyc(2);
    chk("pause_lead", 9'h15a, {pause_active, pause_pwm});
    chk("state", ST_NORM, state);
    wait_for(0, 200, n);
    chk("lead_len", 1'h1, n >= 85 && n <= 95);
    cyc(10);
    chk("pause_trail", 9'h1a5, {pause_active, pause_pwm});
    wait_for(2, 300, n);
    chk("trail_len", 1'h1, n >= 170 && n <= 185);
    wr(REG_PAUSE, 32'h0);
    wr(REG_CMD, 32'h1);
    wait_for(0, 10, n);
    chk("lead_skip", 1'h1, n <= 3 && !pause_active);
    cyc(10);
    chk("trail_skip", 1'h0, pause_active);
    wr(REG_CMD, 32'h2);
    cyc(2);
    chk("state", ST_STBY, state);
    $display("test pause done");
    results();
  end
endmodule
bind lfmc_ctrl lfmc_ctrl_monitor #(.N_LED(N_LED)) i_mon (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .over_temp(over_temp), .first_pwm1(first_pwm1),
  .engine_go(engine_go), .pause_active(pause_active), .pause_pwm(pause_pwm), .led_on(led_on),
  .open_thr_high(open_thr_high), .short_thr_sel(short_thr_sel), .state(state));
